// ==== logic/pspc_pkg.sv ====
// Shared constants for the parallel slave port and its control pins
package pspc_pkg;
   localparam int DATA_W = 8;
   localparam int CTRL_W = 3;
   localparam int ADDR_W = 3;
   // Avalon word addresses of the device registers
   localparam logic [2:0] OFS_DATA_PINS = 3'h0;
   localparam logic [2:0] OFS_DATA_LATCH = 3'h1;
   localparam logic [2:0] OFS_DATA_DIR = 3'h2;
   localparam logic [2:0] OFS_CTRL_STAT = 3'h3;
   localparam logic [2:0] OFS_CTRL_PINS = 3'h4;
   localparam logic [2:0] OFS_CTRL_LATCH = 3'h5;
   localparam logic [2:0] OFS_ANALOG_CFG = 3'h6;
   localparam logic [2:0] OFS_EVENT = 3'h7;
   // Field positions in the control/status, control pin and event registers
   localparam int BIT_IN_FULL = 7;
   localparam int BIT_OUT_FULL = 6;
   localparam int BIT_IN_OVF = 5;
   localparam int BIT_SLAVE_MODE = 4;
   localparam int BIT_INPUT_ONLY = 3;
   localparam int BIT_PORT_EVENT = 0;
   // Values after reset
   localparam logic [7:0] RST_DATA_DIR = 8'hff;
   localparam logic [7:0] RST_DATA_LATCH = 8'h00;
   localparam logic [2:0] RST_CTRL_DIR = 3'h7;
   localparam logic [2:0] RST_CTRL_LATCH = 3'h0;
   localparam logic [3:0] RST_ANALOG_CFG = 4'h0;
   // Lowest analog config value that frees the control pins for digital use
   localparam logic [3:0] ANALOG_DIGITAL_MIN = 4'ha;
   // Host strobe timing
   localparam int CLK_MHZ = 200;
   localparam int STROBE_NS = 40;
   localparam int SETUP_NS = 10;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ) / 1000;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;
endpackage

// ==== logic/pspc_if.sv ====
// Pin bundle between the slave port device and the external processor
`timescale 1ns/10ps
interface pspc_if;
   logic [7:0] host_d_o;
   logic [7:0] host_d_oe;
   logic [7:0] dev_d_o;
   logic [7:0] dev_d_oe;
   logic [7:0] d_lvl;
   logic [2:0] host_ctrl_o;
   logic [2:0] host_ctrl_oe;
   logic [2:0] dev_ctrl_o;
   logic [2:0] dev_ctrl_oe;
   logic [2:0] ctrl_lvl;
   logic input_only_lvl;
   // Weak pull-up when nobody drives; device wins a clash
   assign d_lvl = (dev_d_oe & dev_d_o) | (~dev_d_oe & host_d_oe & host_d_o)
                  | (~dev_d_oe & ~host_d_oe);
   assign ctrl_lvl = (dev_ctrl_oe & dev_ctrl_o)
                     | (~dev_ctrl_oe & host_ctrl_oe & host_ctrl_o)
                     | (~dev_ctrl_oe & ~host_ctrl_oe);
   modport dev_mp (
      input d_lvl,
      input ctrl_lvl,
      input input_only_lvl,
      output dev_d_o,
      output dev_d_oe,
      output dev_ctrl_o,
      output dev_ctrl_oe
   );
   modport host_mp (
      input d_lvl,
      output host_d_o,
      output host_d_oe,
      output host_ctrl_o,
      output host_ctrl_oe,
      output input_only_lvl
   );
endinterface

// ==== logic/pspc_host.sv ====
// External processor end: runs strobe cycles on the parallel port
`timescale 1ns/10ps
module pspc_host (
   input wire logic sys_clk,
   input wire logic arst_n,
   pspc_if.host_mp pins,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_wdata,
   input wire logic input_only_level,
   output logic cmd_busy_ff,
   output logic rsp_valid_ff,
   output logic [7:0] rsp_rdata_ff
);
   typedef enum logic [1:0] {PSPC_IDLE, PSPC_SETUP, PSPC_STROBE, PSPC_HOLD} pspc_hst_type;
   pspc_hst_type state_ff;
   logic [pspc_pkg::CNT_W-1:0] cnt_ff;
   logic is_write_ff;
   logic [7:0] d_meta_ff;
   logic [7:0] d_sync_ff;
   logic [7:0] d_o_ff;
   logic d_oe_ff;
   logic [2:0] ctrl_ff;
   logic lvl_ff;

   assign pins.host_d_o = d_o_ff;
   assign pins.host_d_oe = {8{d_oe_ff}};
   assign pins.host_ctrl_o = ctrl_ff;
   assign pins.host_ctrl_oe = 3'h7;
   assign pins.input_only_lvl = lvl_ff;

   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         d_meta_ff <= 8'h00;
         d_sync_ff <= 8'h00;
         lvl_ff <= 1'b1;
      end
      else
      begin
         d_meta_ff <= pins.d_lvl;
         d_sync_ff <= d_meta_ff;
         lvl_ff <= input_only_level;
      end

   // ctrl_ff bit 0 read strobe, bit 1 write strobe, bit 2 chip select, all low active
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         state_ff <= PSPC_IDLE;
         cnt_ff <= '0;
         is_write_ff <= 1'b0;
         d_o_ff <= 8'h00;
         d_oe_ff <= 1'b0;
         ctrl_ff <= 3'h7;
         cmd_busy_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= 8'h00;
      end
      else
      begin
         rsp_valid_ff <= 1'b0;
         case (state_ff)
            PSPC_IDLE:
               if (cmd_valid)
               begin
                  state_ff <= PSPC_SETUP;
                  is_write_ff <= cmd_write;
                  d_o_ff <= cmd_wdata;
                  d_oe_ff <= cmd_write;
                  ctrl_ff <= 3'h3;
                  cmd_busy_ff <= 1'b1;
                  cnt_ff <= pspc_pkg::CNT_W'(pspc_pkg::SETUP_CYC);
               end
            PSPC_SETUP:
               if (cnt_ff <= 1)
               begin
                  // Strobe falls while chip select already low [R12]
                  state_ff <= PSPC_STROBE;
                  ctrl_ff <= is_write_ff ? 3'h1 : 3'h2;
                  cnt_ff <= pspc_pkg::CNT_W'(pspc_pkg::STROBE_CYC);
               end
               else
                  cnt_ff <= cnt_ff - 1'b1;
            PSPC_STROBE:
               if (cnt_ff <= 1)
               begin
                  // Strobe long enough for device sync and drive delay [R11]
                  state_ff <= PSPC_HOLD;
                  ctrl_ff <= 3'h7;
                  if (!is_write_ff)
                     rsp_rdata_ff <= d_sync_ff;
               end
               else
                  cnt_ff <= cnt_ff - 1'b1;
            PSPC_HOLD:
            begin
               // Data held one cycle past the rising strobes
               state_ff <= PSPC_IDLE;
               d_oe_ff <= 1'b0;
               cmd_busy_ff <= 1'b0;
               rsp_valid_ff <= 1'b1;
            end
            default:
               state_ff <= PSPC_IDLE;
         endcase
      end
endmodule

// ==== logic/pspc_dev.sv ====
// Device end: parallel slave port, control pins and Avalon register file
// Function
// [R1] Direction bit one tristates, zero drives latch
// [R2] Analog-selected control pin reads as zero
// [R3] Software keeps analog pins configured as inputs
// [R4] Control pins start as analog after reset
// [R5] Driven control pin ignores analog selection
// [R6] Fourth pin: digital input or master clear
// [R7] Small package: only input-only bit three
// [R8] Slave mode unless multi-output PWM runs
// [R9] Pins zero, one, two: read, write, select
// [R10] Software sets strobe pins input, digital config
// [R11] Processor accesses data latch without device clock
// [R12] Write runs from both low to either high
// [R13] Write end sets input-full and port event
// [R14] Read start drives latch, clears output-full
// [R15] CPU latch write sets output-full unless reading
// [R16] Read end releases pins, sets port event
// [R17] Software waits for event then polls flags
// [R18] Read drives output latch over port data
// [R19] Write end with input-full sets overflow
// [R20] Strobes synchronised before level detection
// [R21] Write end captures pins into input latch
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pspc_dev #(
   parameter bit SMALL_PKG = 1'b0
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   pspc_if.dev_mp pins,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata_ff,
   output logic avs_waitrequest_ff,
   input wire logic master_clear_enable_cfg,
   input wire logic pwm_multi_output,
   output logic master_clear_req_ff
);
   logic [7:0] d_meta_ff;
   logic [7:0] d_sync_ff;
   logic [2:0] c_meta_ff;
   logic [2:0] c_sync_ff;
   logic i_meta_ff;
   logic i_sync_ff;
   logic [7:0] out_latch_ff;
   logic [7:0] in_latch_ff;
   logic [7:0] data_dir_ff;
   logic [2:0] ctrl_dir_ff;
   logic [2:0] ctrl_latch_ff;
   logic [3:0] analog_cfg_ff;
   logic slave_mode_ff;
   logic in_full_ff;
   logic out_full_ff;
   logic in_ovf_ff;
   logic port_event_ff;
   logic wr_act_ff;
   logic rd_act_ff;
   logic [7:0] d_o_ff;
   logic [7:0] d_oe_ff;
   logic [2:0] c_o_ff;
   logic [2:0] c_oe_ff;
   logic slave_en;
   logic wr_act;
   logic rd_act;
   logic wr_end;
   logic rd_end;
   logic pins_analog;
   logic acc;
   logic cpu_wr;
   logic cpu_rd;
   logic [7:0] ctrl_pins_view;
   logic [7:0] rd_mux;

   assign pins.dev_d_o = d_o_ff;
   assign pins.dev_d_oe = d_oe_ff;
   assign pins.dev_ctrl_o = c_o_ff;
   assign pins.dev_ctrl_oe = c_oe_ff;

   // Pins arrive from outside the clock domain [R20]
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         d_meta_ff <= 8'hff;
         d_sync_ff <= 8'hff;
         c_meta_ff <= 3'h7;
         c_sync_ff <= 3'h7;
         i_meta_ff <= 1'b1;
         i_sync_ff <= 1'b1;
      end
      else
      begin
         d_meta_ff <= pins.d_lvl;
         d_sync_ff <= d_meta_ff;
         c_meta_ff <= pins.ctrl_lvl;
         c_sync_ff <= c_meta_ff;
         i_meta_ff <= pins.input_only_lvl;
         i_sync_ff <= i_meta_ff;
      end

   // No slave port at all on the small package [R7]
   assign slave_en = slave_mode_ff && !pwm_multi_output && !SMALL_PKG; // [R8]
   // Read strobe pin 0, write strobe pin 1, chip select pin 2 [R9]
   assign wr_act = slave_en && !c_sync_ff[2] && !c_sync_ff[1]; // [R12]
   assign rd_act = slave_en && !c_sync_ff[2] && !c_sync_ff[0];
   assign wr_end = wr_act_ff && !wr_act; // [R12]
   assign rd_end = rd_act_ff && !rd_act;
   assign pins_analog = analog_cfg_ff < pspc_pkg::ANALOG_DIGITAL_MIN;

   // Avalon: one wait cycle, read data loaded while waitrequest is high
   assign acc = (avs_read || avs_write) && !avs_waitrequest_ff;
   assign cpu_wr = acc && avs_write;
   assign cpu_rd = acc && avs_read;

   always_comb
   begin
      ctrl_pins_view = 8'h00;
      // Input-only pin reads only while master clear is off [R6]
      ctrl_pins_view[pspc_pkg::BIT_INPUT_ONLY] = !master_clear_enable_cfg && i_sync_ff;
      if (!SMALL_PKG && !pins_analog)
         ctrl_pins_view[2:0] = c_sync_ff; // [R2]
   end

   always_comb
   begin
      rd_mux = 8'h00;
      case (avs_address)
         pspc_pkg::OFS_DATA_PINS: rd_mux = slave_en ? in_latch_ff : d_sync_ff;
         pspc_pkg::OFS_DATA_LATCH: rd_mux = out_latch_ff;
         pspc_pkg::OFS_DATA_DIR: rd_mux = data_dir_ff;
         pspc_pkg::OFS_CTRL_STAT: rd_mux = {in_full_ff, out_full_ff, in_ovf_ff, slave_mode_ff,
                                            1'b0, ctrl_dir_ff};
         pspc_pkg::OFS_CTRL_PINS: rd_mux = ctrl_pins_view;
         pspc_pkg::OFS_CTRL_LATCH: rd_mux = {5'h00, ctrl_latch_ff};
         pspc_pkg::OFS_ANALOG_CFG: rd_mux = {4'h0, analog_cfg_ff};
         pspc_pkg::OFS_EVENT: rd_mux = {7'h00, port_event_ff};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         avs_waitrequest_ff <= 1'b1;
         avs_readdata_ff <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest_ff <= !((avs_read || avs_write) && avs_waitrequest_ff);
         if (avs_read && avs_waitrequest_ff)
            avs_readdata_ff <= {24'h00_0000, rd_mux};
      end

   // Software configuration registers
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         out_latch_ff <= pspc_pkg::RST_DATA_LATCH;
         data_dir_ff <= pspc_pkg::RST_DATA_DIR;
         ctrl_dir_ff <= pspc_pkg::RST_CTRL_DIR;
         ctrl_latch_ff <= pspc_pkg::RST_CTRL_LATCH;
         analog_cfg_ff <= pspc_pkg::RST_ANALOG_CFG; // [R4]
         slave_mode_ff <= 1'b0;
      end
      else if (cpu_wr)
         case (avs_address)
            pspc_pkg::OFS_DATA_PINS,
            pspc_pkg::OFS_DATA_LATCH: out_latch_ff <= avs_writedata[7:0];
            pspc_pkg::OFS_DATA_DIR: data_dir_ff <= avs_writedata[7:0];
            pspc_pkg::OFS_CTRL_STAT:
            begin
               slave_mode_ff <= avs_writedata[pspc_pkg::BIT_SLAVE_MODE];
               ctrl_dir_ff <= avs_writedata[2:0];
            end
            pspc_pkg::OFS_CTRL_PINS,
            pspc_pkg::OFS_CTRL_LATCH: ctrl_latch_ff <= avs_writedata[2:0];
            pspc_pkg::OFS_ANALOG_CFG: analog_cfg_ff <= avs_writedata[3:0];
            default: ;
         endcase

   // Cycle trackers and input latch
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         wr_act_ff <= 1'b0;
         rd_act_ff <= 1'b0;
         in_latch_ff <= 8'h00;
      end
      else
      begin
         wr_act_ff <= wr_act;
         rd_act_ff <= rd_act;
         // Data synced with the same delay as the strobes [R21]
         if (wr_end)
            in_latch_ff <= d_sync_ff;
      end

   // Status flags; hardware set or clear beats software access
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         in_full_ff <= 1'b0;
         out_full_ff <= 1'b0;
         in_ovf_ff <= 1'b0;
         port_event_ff <= 1'b0;
      end
      else
      begin
         if (wr_end)
            in_full_ff <= 1'b1; // [R13]
         else if (cpu_rd && avs_address == pspc_pkg::OFS_DATA_PINS && slave_en)
            in_full_ff <= 1'b0;
         if (rd_act)
            out_full_ff <= 1'b0; // [R14] [R15]
         else if (cpu_wr && (avs_address == pspc_pkg::OFS_DATA_PINS
                             || avs_address == pspc_pkg::OFS_DATA_LATCH))
            out_full_ff <= 1'b1; // [R15]
         if (wr_end && in_full_ff)
            in_ovf_ff <= 1'b1; // [R19]
         else if (cpu_wr && avs_address == pspc_pkg::OFS_CTRL_STAT
                  && !avs_writedata[pspc_pkg::BIT_IN_OVF])
            in_ovf_ff <= 1'b0; // [R19]
         if (wr_end || rd_end)
            port_event_ff <= 1'b1; // [R13] [R16]
         else if (cpu_wr && avs_address == pspc_pkg::OFS_EVENT
                  && avs_writedata[pspc_pkg::BIT_PORT_EVENT])
            port_event_ff <= 1'b0;
      end

   // Pin drivers
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         d_o_ff <= 8'h00;
         d_oe_ff <= 8'h00;
         c_o_ff <= 3'h0;
         c_oe_ff <= 3'h0;
         master_clear_req_ff <= 1'b0;
      end
      else
      begin
         // Latch written during a read shows up next cycle [R15]
         if (slave_en)
         begin
            d_o_ff <= out_latch_ff; // [R18]
            d_oe_ff <= {8{rd_act}}; // [R14] [R16]
         end
         else
         begin
            d_o_ff <= out_latch_ff;
            d_oe_ff <= ~data_dir_ff;
         end
         // Analog selection does not gate the driver [R1] [R5] [R3]
         c_o_ff <= ctrl_latch_ff;
         c_oe_ff <= SMALL_PKG ? 3'h0 : ~ctrl_dir_ff; // [R1] [R7]
         master_clear_req_ff <= master_clear_enable_cfg && !i_sync_ff; // [R6]
      end
endmodule

// ==== sim/pspc_props.sv ====
// Pin-level assertions for the slave port pair
`timescale 1ns/10ps
module pspc_props (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [7:0] dev_d_oe,
   input wire logic [2:0] dev_ctrl_o,
   input wire logic [2:0] dev_ctrl_oe,
   input wire logic [2:0] ctrl_lvl
);
   wire logic rd_act;
   wire logic wr_act;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // Strobes active low: bit 0 read, bit 1 write, bit 2 select
   assign rd_act = ~ctrl_lvl[2] & ~ctrl_lvl[0];
   assign wr_act = ~ctrl_lvl[2] & ~ctrl_lvl[1];
   byte_drive_a: assert property (dev_d_oe == 8'h00 || dev_d_oe == 8'hff)
      else $error("data enable split across bits");
   sync_delay_a: assert property ($rose(dev_d_oe[0]) |-> $past(rd_act) && $past(rd_act, 2))
      else $error("data drive before strobe synchronised");
   read_drive_a: assert property ($rose(rd_act) |-> ##[2:6] dev_d_oe == 8'hff)
      else $error("read strobe not answered with data drive");
   read_hold_a: assert property (rd_act && dev_d_oe == 8'hff |=> dev_d_oe == 8'hff)
      else $error("data drive dropped during read");
   read_release_a: assert property ($fell(rd_act) |-> ##[2:6] dev_d_oe == 8'h00)
      else $error("data pins not released after read");
   write_quiet_a: assert property (wr_act [*3] |-> dev_d_oe == 8'h00)
      else $error("device drives data during host write");
   reset_dir_a: assert property ($rose(arst_n) |-> dev_ctrl_oe == 3'h0 && dev_d_oe == 8'h00)
      else $error("pins driven right after reset");
   ctrl_hold_a: assert property (dev_ctrl_oe == 3'h7 [*2] |-> $stable(dev_ctrl_o))
      else $error("driven control pins changed without latch write");
   read_cov: cover property ($rose(dev_d_oe[0]));
   write_cov: cover property (wr_act [*4]);
   ctrl_cov: cover property (dev_ctrl_oe == 3'h7);
endmodule

// ==== sim/pspc_test.sv ====
// Self-checking bench joining device end and processor end
`timescale 1ns/10ps
module pspc_test;
   typedef struct packed {
      logic [1:0] op;
      logic [2:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
   } pspc_row_type;
   // op: 0 register read, 1 register write, 2 strobe read, 3 strobe write
   logic sys_clk;
   logic arst_n;
   logic [2:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata_ff;
   logic avs_waitrequest_ff;
   logic master_clear_enable_cfg;
   logic pwm_multi_output;
   logic master_clear_req_ff;
   logic cmd_valid;
   logic cmd_write;
   logic [7:0] cmd_wdata;
   logic input_only_level;
   logic cmd_busy_ff;
   logic rsp_valid_ff;
   logic [7:0] rsp_rdata_ff;
   logic [7:0] dummy;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   pspc_row_type rows [0:27] = '{
      '{2'h0, 3'h2, 8'h00, 8'hff},
      '{2'h0, 3'h3, 8'h00, 8'h07},
      '{2'h0, 3'h1, 8'h00, 8'h00},
      '{2'h0, 3'h5, 8'h00, 8'h00},
      '{2'h0, 3'h6, 8'h00, 8'h00},
      '{2'h0, 3'h7, 8'h00, 8'h00},
      '{2'h0, 3'h4, 8'h00, 8'h08},
      '{2'h1, 3'h5, 8'h05, 8'h00},
      '{2'h1, 3'h3, 8'h00, 8'h00},
      '{2'h0, 3'h4, 8'h00, 8'h08},
      '{2'h1, 3'h6, 8'h0a, 8'h00},
      '{2'h0, 3'h4, 8'h00, 8'h0d},
      '{2'h1, 3'h3, 8'h07, 8'h00},
      '{2'h0, 3'h4, 8'h00, 8'h0f},
      '{2'h1, 3'h3, 8'h17, 8'h00},
      '{2'h3, 3'h0, 8'ha5, 8'h00},
      '{2'h0, 3'h7, 8'h00, 8'h01},
      '{2'h0, 3'h3, 8'h00, 8'h97},
      '{2'h3, 3'h0, 8'h3c, 8'h00},
      '{2'h0, 3'h3, 8'h00, 8'hb7},
      '{2'h0, 3'h0, 8'h00, 8'h3c},
      '{2'h0, 3'h3, 8'h00, 8'h37},
      '{2'h1, 3'h3, 8'h17, 8'h00},
      '{2'h1, 3'h0, 8'h69, 8'h00},
      '{2'h0, 3'h3, 8'h00, 8'h57},
      '{2'h1, 3'h7, 8'h01, 8'h00},
      '{2'h2, 3'h0, 8'h00, 8'h69},
      '{2'h0, 3'h3, 8'h00, 8'h17}
   };
   pspc_if pins ();
   pspc_dev u_pspc_dev (
      .sys_clk(sys_clk), .arst_n(arst_n), .pins(pins),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
      .avs_waitrequest_ff(avs_waitrequest_ff),
      .master_clear_enable_cfg(master_clear_enable_cfg),
      .pwm_multi_output(pwm_multi_output), .master_clear_req_ff(master_clear_req_ff)
   );
   pspc_host u_pspc_host (
      .sys_clk(sys_clk), .arst_n(arst_n), .pins(pins),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
      .input_only_level(input_only_level), .cmd_busy_ff(cmd_busy_ff),
      .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff)
   );
   pspc_props u_props (
      .sys_clk(sys_clk), .arst_n(arst_n), .dev_d_oe(pins.dev_d_oe),
      .dev_ctrl_o(pins.dev_ctrl_o), .dev_ctrl_oe(pins.dev_ctrl_oe), .ctrl_lvl(pins.ctrl_lvl)
   );
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task wrap_up();
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Request held until the edge that samples waitrequest low
   task av_op(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h000000, d};
      do @(posedge sys_clk); while (avs_waitrequest_ff !== 1'b0);
      q = avs_readdata_ff[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task host_op(input logic wr, input logic [7:0] d, output logic [7:0] q);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_wdata <= d;
      // Taken at the edge that finds the processor end idle
      do @(posedge sys_clk); while (cmd_busy_ff !== 1'b0);
      cmd_valid <= 1'b0;
      do @(posedge sys_clk); while (rsp_valid_ff !== 1'b1);
      q = rsp_rdata_ff;
   endtask
   task do_row(input pspc_row_type r);
      logic [7:0] q;
      if (r.op[1])
         host_op(r.op[0], r.data, q);
      else
      begin
         // Pin levels reach the register view only through the synchroniser
         if (!r.op[0])
            repeat (4) @(posedge sys_clk);
         av_op(r.op[0], r.addr, r.data, q);
      end
      if (!r.op[0])
         chk(q, r.exp);
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      // Whole run needs about three hundred cycles
      if (cycles == 20000)
      begin
         n_errors++;
         wrap_up();
      end
   end
   initial
   begin
      arst_n = 1'b0;
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      {cmd_valid, cmd_write, cmd_wdata, pwm_multi_output, master_clear_enable_cfg} = '0;
      input_only_level = 1'b1;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      foreach (rows[i])
         do_row(rows[i]);
      do_row('{2'h0, 3'h7, 8'h00, 8'h01});
      do_row('{2'h1, 3'h7, 8'h01, 8'h00});
      fork
         host_op(1'b0, 8'h00, dummy);
         begin
            do @(posedge sys_clk); while (pins.dev_d_oe !== 8'hff);
            do_row('{2'h1, 3'h0, 8'h5a, 8'h00});
            repeat (2) @(posedge sys_clk);
            chk(pins.d_lvl, 8'h5a);
         end
      join
      do_row('{2'h0, 3'h3, 8'h00, 8'h17});
      do_row('{2'h1, 3'h7, 8'h01, 8'h00});
      @(posedge sys_clk);
      pwm_multi_output <= 1'b1;
      do_row('{2'h3, 3'h0, 8'h11, 8'h00});
      do_row('{2'h0, 3'h3, 8'h00, 8'h17});
      do_row('{2'h0, 3'h7, 8'h00, 8'h00});
      @(posedge sys_clk);
      pwm_multi_output <= 1'b0;
      master_clear_enable_cfg <= 1'b1;
      input_only_level <= 1'b0;
      repeat (8) @(negedge sys_clk);
      chk({7'h00, master_clear_req_ff}, 8'h01);
      do_row('{2'h0, 3'h4, 8'h00, 8'h07});
      @(posedge sys_clk);
      master_clear_enable_cfg <= 1'b0;
      input_only_level <= 1'b1;
      repeat (8) @(negedge sys_clk);
      chk({7'h00, master_clear_req_ff}, 8'h00);
      // Reset in mid-run must drop all flags and modes
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      do_row('{2'h0, 3'h3, 8'h00, 8'h07});
      do_row('{2'h0, 3'h4, 8'h00, 8'h08});
      wrap_up();
   end
endmodule
